//--- rtl/qdac_top.sv
// Purpose: Digital front end of a quad 12-bit converter: serial word
//          intake, per-channel input registers and output registers
// Assumes: Host frames carry exactly sixteen shift edges per word;
//          strobes and select pins are asynchronous to clk_i
// Notes:   The shift side runs on the OR of chip select and serial clock;
//          word framing realigns only at reset, so one stray shift edge
//          moves every later word by a bit. Strobe pulses shorter than
//          two clk_i cycles can be missed. The reset code is taken once,
//          at the first clk_i edge after release.
`timescale 1ns/1ps
module qdac_top
  import qdac_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           serial_clk_i,
  input  wire logic                           chip_select_n_i,
  input  wire logic                           serial_data_in_i,
  input  wire logic                           input_latch_strobe_n_i,
  input  wire logic                           output_update_strobe_n_i,
  input  wire logic                           reset_code_select_i,
  input  wire logic                           overrun_clr_i,
  output wire logic [NCH-1:0][CODE_W-1:0]     dac_code_o,
  output logic                                overrun_o,
  output logic                                word_waiting_o,
  output logic                                fifo_full_o
);

  // ------------------------------------------------------------------
  // Link side, clocked by the combined shift clock
  // ------------------------------------------------------------------
  wire                  shift_clk;
  logic [WORD_W-1:0]    shreg_q;
  logic [BITCNT_W-1:0]  bitcnt_q;
  logic [WORD_W-1:0]    word_q;
  logic                 word_tog_q;
  wire  [WORD_W-1:0]    shreg_next;
  wire                  word_done;

  // Either pin can act as the shift clock; a high chip select parks it
  assign shift_clk = serial_clk_i | chip_select_n_i;

  // Next contents of the shift register, MSB arrives first
  assign shreg_next = {shreg_q[WORD_W-2:0], serial_data_in_i};
  assign word_done  = (bitcnt_q == LAST_BIT);

  // Data path only: reset leaves the shift register untouched
  always_ff @(posedge shift_clk) begin
    shreg_q <= shreg_next;
  end

  // Word framing; an extra edge from a late chip select rise would
  // misalign every following word until the next reset
  always_ff @(posedge shift_clk or posedge rst_i) begin
    if (rst_i) begin
      bitcnt_q   <= '0;
      word_q     <= '0;
      word_tog_q <= 1'b0;
    end else begin
      bitcnt_q <= bitcnt_q + 1'b1;
      if (word_done) begin
        word_q     <= shreg_next;
        word_tog_q <= ~word_tog_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // Synchronisers into clk_i; first stages feed only second stages
  // ------------------------------------------------------------------
  logic tog_s1;
  logic tog_s2;
  logic latch_s1;
  logic latch_s2;
  logic upd_s1;
  logic upd_s2;
  logic rsel_s1;
  logic rsel_s2;

  // Word toggle from the link domain; no reset, so a reset shorter than
  // two clk_i cycles could show a stale toggle as a new word
  always_ff @(posedge clk_i) begin
    tog_s1 <= word_tog_q;
    tog_s2 <= tog_s1;
  end

  // Latch strobe pin
  always_ff @(posedge clk_i) begin
    latch_s1 <= input_latch_strobe_n_i;
    latch_s2 <= latch_s1;
  end

  // Update strobe pin
  always_ff @(posedge clk_i) begin
    upd_s1 <= output_update_strobe_n_i;
    upd_s2 <= upd_s1;
  end

  // Reset code pin; no reset here so it is settled at release
  always_ff @(posedge clk_i) begin
    rsel_s1 <= reset_code_select_i;
    rsel_s2 <= rsel_s1;
  end

  // ------------------------------------------------------------------
  // Edge detection and reset code capture
  // ------------------------------------------------------------------
  logic              tog_s3;
  logic              latch_s3;
  logic              released_q;
  logic [CODE_W-1:0] rcode_q;
  wire               word_evt;
  wire               latch_rise;
  wire  [CODE_W-1:0] rcode_now;

  // Detector stages reset to the idle levels (toggle low, strobe high),
  // so release from a reset of two or more clk_i cycles never looks like a word or a latch edge
  assign word_evt   = tog_s2 ^ tog_s3;
  assign latch_rise = latch_s2 & ~latch_s3;

  // Reset code is taken from the select pin at the first edge after
  // release, then frozen until the next reset
  assign rcode_now = released_q ? rcode_q
                              : (rsel_s2 ? MID_CODE : ZERO_CODE);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_s3     <= 1'b0;
      latch_s3   <= 1'b1;
      released_q <= 1'b0;
      rcode_q    <= ZERO_CODE;
    end else begin
      tog_s3     <= tog_s2;
      latch_s3   <= latch_s2;
      released_q <= 1'b1;
      if (!released_q) begin
        rcode_q <= rcode_now;
      end
    end
  end

  // ------------------------------------------------------------------
  // Word hand-off into the buffer
  // ------------------------------------------------------------------
  qdac_stream_if #(.W(WORD_W)) push_if ();
  qdac_stream_if #(.W(WORD_W)) pop_if ();

  logic              pend_q;
  logic [WORD_W-1:0] pend_data_q;
  wire               push_fire;
  wire               lost_word;

  // Holding word is stable for sixteen shift edges, far longer than
  // the toggle takes to cross, so sampling it here is safe
  assign push_fire    = pend_q & push_if.ready;
  assign lost_word    = word_evt & pend_q & ~push_fire;
  assign push_if.valid = pend_q;
  assign push_if.data  = pend_data_q;

  // One word waits here while the buffer is full; a newer one
  // replaces it and raises the overrun flag
  // Trade-off: only the newest word survives a long full spell
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end else begin
      if (word_evt) begin
        pend_q      <= 1'b1;
        pend_data_q <= word_q;
      end else if (push_fire) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Buffer lets the host stream words faster than the latch strobe
  // retires them; its depth is the DEPTH parameter
  qdac_fifo #(
    .W (WORD_W),
    .D (DEPTH)
  ) u_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .wr_if (push_if.sink),
    .rd_if (pop_if.source)
  );

  // ------------------------------------------------------------------
  // Head word decode
  // ------------------------------------------------------------------
  wire              channel_select_hi;
  wire              channel_select_lo;
  wire [SEL_W-1:0]  head_sel;
  wire [CODE_W-1:0] head_code;
  wire              head_open;
  wire              dac_follow;

  assign channel_select_hi = pop_if.data[SEL_HI];
  assign channel_select_lo = pop_if.data[SEL_LO];
  assign head_sel  = {channel_select_hi, channel_select_lo};
  assign head_code = pop_if.data[CODE_MSB:0];

  // Latch strobe low opens the addressed register to the head word;
  // its rising edge closes it and retires that word
  assign head_open    = ~latch_s2 & pop_if.valid;
  assign pop_if.ready = latch_rise;

  // Update strobe low: output registers follow, which also gives the
  // all-at-once copy on its falling edge
  assign dac_follow = ~upd_s2;

  // ------------------------------------------------------------------
  // Per-channel double buffer
  // ------------------------------------------------------------------
  // Channel index matches the select value: 0 is A through 3 is D
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      logic [CODE_W-1:0] in_q;
      logic              in_fresh_q;
      logic [CODE_W-1:0] dac_q;
      logic              dac_fresh_q;
      logic [CODE_W-1:0] out_q;
      wire               wr_en;
      wire  [CODE_W-1:0] in_val;
      wire  [CODE_W-1:0] dac_val;

      assign wr_en   = head_open & (head_sel == SEL_W'(g));
      // Fresh flags stand for the reset code until first written
      assign in_val  = in_fresh_q ? rcode_now : in_q;
      assign dac_val = dac_fresh_q ? rcode_now : dac_q;

      // Input register: loading it leaves the output alone while the update strobe is high
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          in_q       <= ZERO_CODE;
          in_fresh_q <= 1'b1;
        end else if (wr_en) begin
          in_q       <= head_code;
          in_fresh_q <= 1'b0;
        end
      end

      // Output register: copies all channels in the same cycle
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          dac_q       <= ZERO_CODE;
          dac_fresh_q <= 1'b1;
        end else if (dac_follow) begin
          dac_q       <= in_val;
          dac_fresh_q <= 1'b0;
        end
      end

      // Registered code to the converter, straight binary
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          out_q <= ZERO_CODE;
        end else begin
          out_q <= dac_val;
        end
      end

      assign dac_code_o[g] = out_q;
    end
  endgenerate

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  // Overrun: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_o      <= 1'b0;
      word_waiting_o <= 1'b0;
      fifo_full_o    <= 1'b0;
    end else begin
      if (lost_word) begin
        overrun_o <= 1'b1;
      end else if (overrun_clr_i) begin
        overrun_o <= 1'b0;
      end
      word_waiting_o <= pop_if.valid;
      fifo_full_o    <= ~push_if.ready;
    end
  end

endmodule // qdac_top

//--- rtl/qdac_pkg.sv
// Purpose: Shared constants of the quad converter serial front end
// Assumes: Four channels of 12-bit straight binary codes
// Notes:   Word layout is select bits, two spare bits, then the code
package qdac_pkg;

  // Channel and word geometry
  localparam int NCH       = 4;
  localparam int CODE_W    = 12;
  localparam int WORD_W    = 16;
  localparam int SEL_W     = 2;
  localparam int SEL_HI    = 15;
  localparam int SEL_LO    = 14;
  localparam int CODE_MSB  = 11;

  // Serial bit counter; a word completes on the last bit
  localparam int                BITCNT_W = 4;
  localparam logic [BITCNT_W-1:0] LAST_BIT = 4'hF;

  // Reset codes: zero-scale and mid-scale
  localparam logic [CODE_W-1:0] ZERO_CODE = 12'h000;
  localparam logic [CODE_W-1:0] MID_CODE  = 12'h800;

  // Full-scale span in steps
  localparam int CODE_STEPS = 4096;

  // Word buffer between the link and the registers
  localparam int FIFO_DEPTH = 4;

endpackage : qdac_pkg

//--- rtl/qdac_stream_if.sv
// Purpose: Valid/ready word stream between the core and its buffer
// Assumes: Single clock, data stable while valid and not ready
// Notes:   A word moves on a cycle with valid and ready both high
`timescale 1ns/1ps
interface qdac_stream_if #(
  parameter int W = 16
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  // Producer and consumer views
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : qdac_stream_if

//--- rtl/qdac_fifo.sv
// Purpose: Small synchronous word buffer with valid/ready on both sides
// Assumes: One clock; depth of at least two
// Notes:   Head word shows on the read side without a pop
`timescale 1ns/1ps
module qdac_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  qdac_stream_if.sink   wr_if,
  qdac_stream_if.source rd_if
);

  localparam int               AW    = $clog2(D);
  localparam int               CW    = $clog2(D + 1);
  localparam logic [AW-1:0]    LAST  = AW'(D - 1);
  localparam logic [CW-1:0]    FULLC = CW'(D);
  localparam logic [CW-1:0]    ONE   = CW'(1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  wire           push;
  wire           pop;

  // Honest full and empty from the word count
  assign wr_if.ready = (count_q != FULLC);
  assign rd_if.valid = (count_q != '0);
  assign rd_if.data  = mem[rd_ptr_q];
  assign push        = wr_if.valid & wr_if.ready;
  assign pop         = rd_if.valid & rd_if.ready;

  // Storage needs no reset; only the pointers define content
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= wr_if.data;
    end
  end

  // Pointers wrap at the depth, so any depth of two or more works
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + ONE;
      end else if (pop && !push) begin
        count_q <= count_q - ONE;
      end
    end
  end

endmodule // qdac_fifo

//--- dv/qdac_checker.sv
// Purpose: Port checks for the quad converter front end
// Assumes: Single clock domain, rst_i active high
// Notes:   Bound to qdac_top after the module
`timescale 1ns/1ps
module qdac_checker
  import qdac_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       input_latch_strobe_n_i,
  input wire logic                       output_update_strobe_n_i,
  input wire logic                       reset_code_select_i,
  input wire logic                       overrun_clr_i,
  input wire logic [NCH-1:0][CODE_W-1:0] dac_code_o,
  input wire logic                       overrun_o,
  input wire logic                       word_waiting_o,
  input wire logic                       fifo_full_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Warm-up; synchronisers hold stale levels just after reset
  logic [2:0] warm_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) warm_q <= 3'h0;
    else if (warm_q != 3'h7) warm_q <= warm_q + 3'h1;
  end
  wire logic warm_ok = (warm_q == 3'h7);

  // Quiet windows longer than the strobe path latency
  sequence s_upd_idle;
    output_update_strobe_n_i [*6];
  endsequence
  sequence s_follow;
    (!output_update_strobe_n_i && input_latch_strobe_n_i) [*6];
  endsequence
  sequence s_no_pop;
    input_latch_strobe_n_i [*6];
  endsequence

  property p_reset_code;
    $fell(rst_i) |->
      ##1 dac_code_o == {NCH{reset_code_select_i ? MID_CODE : ZERO_CODE}};
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("dac code not the reset code");
  property p_update_hold;
    s_upd_idle ##0 warm_ok |-> $stable(dac_code_o);
  endproperty
  a_update_hold: assert property (p_update_hold)
    else $error("output moved with update strobe high");
  property p_follow_hold;
    s_follow ##0 warm_ok |-> $stable(dac_code_o);
  endproperty
  a_follow_hold: assert property (p_follow_hold)
    else $error("output moved with latch strobe high");
  property p_no_drain;
    s_no_pop ##0 word_waiting_o |=> word_waiting_o;
  endproperty
  a_no_drain: assert property (p_no_drain)
    else $error("buffer drained without a latch pulse");
  property p_full_waiting;
    fifo_full_o |-> word_waiting_o;
  endproperty
  a_full_waiting: assert property (p_full_waiting)
    else $error("full buffer reports no word");
  property p_ovr_sticky;
    overrun_o && !overrun_clr_i |=> overrun_o;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("overrun flag dropped without clear");
  property p_ovr_clear;
    overrun_clr_i && !fifo_full_o && !$past(fifo_full_o) |=> !overrun_o;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun flag survived clear");
  property p_ovr_cause;
    $rose(overrun_o) |-> fifo_full_o || $past(fifo_full_o);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause)
    else $error("overrun raised with buffer not full");
endmodule // qdac_checker

bind qdac_top qdac_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i),
  .input_latch_strobe_n_i(input_latch_strobe_n_i),
  .output_update_strobe_n_i(output_update_strobe_n_i),
  .reset_code_select_i(reset_code_select_i),
  .overrun_clr_i(overrun_clr_i), .dac_code_o(dac_code_o),
  .overrun_o(overrun_o), .word_waiting_o(word_waiting_o),
  .fifo_full_o(fifo_full_o)
);

//--- dv/qdac_host_model.sv
// Purpose: Host side of the serial link, sixteen bits a frame
// Assumes: Link clock of 80 ns, parked high between frames
// Notes:   Mode 2 ends on a low clock to force one extra shift
`timescale 1ns/1ps
module qdac_host_model (
  output logic serial_clk_o,
  output logic chip_select_n_o,
  output logic serial_data_o
);
  initial begin
    serial_clk_o    = 1'b1;
    chip_select_n_o = 1'b1;
    serial_data_o   = 1'b0;
  end
  // Modes: 0 framed, 1 select as clock, 2 extra edge, 3 deselected
  task automatic send(input logic [15:0] w, input logic [1:0] m);
    #13ns;
    if (m == 2'h1) serial_clk_o = 1'b0;
    chip_select_n_o = (m == 2'h3);
    for (int i = 15; i >= 0; i--) begin
      if (m == 2'h1) chip_select_n_o = 1'b0;
      else serial_clk_o = 1'b0;
      serial_data_o = w[i];
      #40ns;
      if (m == 2'h1) chip_select_n_o = 1'b1;
      else serial_clk_o = 1'b1;
      #40ns;
    end
    if (m == 2'h2) begin
      serial_clk_o = 1'b0;
      #40ns;
    end
    // Select rises with the clock high unless mode 2 asks otherwise
    chip_select_n_o = 1'b1;
    serial_clk_o    = 1'b1;
    #40ns;
    serial_data_o = ~w[0];
  endtask
endmodule // qdac_host_model

//--- dv/test_quad_dac_serial_double_buffer.sv
// Purpose: Self-checking bench for the quad converter front end
// Assumes: Host model drives the link, bench drives the strobes
// Notes:   Codes are random from a fixed seed, with corner values
`timescale 1ns/1ps
module test_quad_dac_serial_double_buffer;
  import qdac_pkg::*;
  logic clk_i, rst_i, sclk, csn, sdata, ld_n, upd_n, rsel, oclr;
  logic ovr, wait_w, full;
  logic [NCH-1:0][CODE_W-1:0] dac, exp_q, nxt;
  logic [15:0] w [6];
  int n_mismatch, total_checks;

  qdac_host_model u_host (.serial_clk_o(sclk), .chip_select_n_o(csn),
    .serial_data_o(sdata));
  qdac_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk),
    .chip_select_n_i(csn), .serial_data_in_i(sdata),
    .input_latch_strobe_n_i(ld_n), .output_update_strobe_n_i(upd_n),
    .reset_code_select_i(rsel), .overrun_clr_i(oclr),
    .dac_code_o(dac), .overrun_o(ovr), .word_waiting_o(wait_w),
    .fifo_full_o(full));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Expected registers after a word lands in its channel
  function automatic logic [NCH-1:0][CODE_W-1:0] after(
      input logic [NCH-1:0][CODE_W-1:0] cur, input logic [15:0] v);
    after = cur;
    after[v[SEL_HI:SEL_LO]] = v[CODE_MSB:0];
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic sel);
    @(negedge clk_i);
    rsel = sel;
    rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    exp_q = {NCH{sel ? MID_CODE : ZERO_CODE}};
    nxt = exp_q;
    check(dac, exp_q);
  endtask

  // Word reaches the buffer within six cycles of its last edge
  task automatic push(input logic [15:0] v, input logic [1:0] m);
    u_host.send(v, m);
    repeat (8) @(negedge clk_i);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b0;
    repeat (4) @(negedge clk_i);
    s = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask

  initial begin
    {rst_i, ld_n, upd_n, rsel, oclr} = 5'h1F;
    oclr = 1'b0;
    void'($urandom(32'h1081));
    do_reset(1'b1);
    // Double buffering: four channels load, outputs hold, then all at once
    for (int i = 0; i < NCH; i++) begin
      w[i] = {i[1:0], 2'($urandom), (i == 0) ? 12'hFFF : 12'($urandom)};
      push(w[i], 2'(i % 2));
      pulse(ld_n);
      nxt = after(nxt, w[i]);
      check(dac, exp_q);
    end
    pulse(upd_n);
    exp_q = nxt;
    check(dac, exp_q);
    // Update held low: each latch pulse reaches its output
    upd_n = 1'b0;
    for (int i = 0; i < 2; i++) begin
      w[i] = {2'($urandom), 2'h0, (i == 0) ? 12'h000 : 12'($urandom)};
      push(w[i], 2'h0);
      pulse(ld_n);
      exp_q = after(exp_q, w[i]);
      check(dac, exp_q);
    end
    // Deselected clocking must not shift
    push(16'($urandom), 2'h3);
    w[0] = 16'($urandom);
    push(w[0], 2'h0);
    pulse(ld_n);
    exp_q = after(exp_q, w[0]);
    check(dac, exp_q);
    // Overflow: four buffered, one waiting, the sixth replaces it
    for (int i = 0; i < 6; i++) begin
      w[i] = 16'($urandom);
      push(w[i], 2'h0);
    end
    check({full, ovr}, 2'h3);
    for (int i = 0; i < 6; i++) begin
      if (i != 4) begin
        pulse(ld_n);
        exp_q = after(exp_q, w[i]);
        check(dac, exp_q);
      end
    end
    check({wait_w, ovr}, 2'h1);
    @(negedge clk_i);
    oclr = 1'b1;
    @(negedge clk_i);
    oclr = 1'b0;
    @(negedge clk_i);
    check(ovr, 1'b0);
    // Select rising on a low clock misaligns the next word by one bit
    w[0] = 16'($urandom);
    w[1] = 16'($urandom);
    push(w[0], 2'h2);
    pulse(ld_n);
    push(w[1], 2'h0);
    pulse(ld_n);
    exp_q = after(after(exp_q, w[0]), {w[0][0], w[1][15:1]});
    check(dac, exp_q);
    do_reset(1'b0);
    wrap_up();
  end

  initial begin
    #2ms;
    n_mismatch++;
    wrap_up();
  end
endmodule // test_quad_dac_serial_double_buffer
